// ---- bench/ccp_host_model.sv ----
`timescale 1ns/1ps
// ============================================================================
// host side of the serial port
// ============================================================================
module ccp_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_dev_sdio,
  input  wire logic i_dev_sdio_oe,
  input  wire logic i_dev_sdo,
  input  wire logic i_dev_sdo_oe,
  output logic      o_sclk,
  output logic      o_sel_n,
  output logic      o_sdio
);
  logic drv_en;
  logic drv_bit;
  logic sdo_wire;

  // wires with pulldowns: a released pin reads low
  assign o_sdio   = i_dev_sdio_oe ? i_dev_sdio : (drv_en ? drv_bit : 1'b0);
  assign sdo_wire = i_dev_sdo_oe ? i_dev_sdo : 1'b0;

  initial begin
    o_sclk  = 1'b0;
    o_sel_n = 1'b1;
    drv_en  = 1'b0;
    drv_bit = 1'b0;
  end

  // six clocks a phase, twice the minimum the port needs
  task automatic frame(input logic [23:0] w, input int nbits, input logic four, output logic [15:0] rv);
    rv = '0;
    @(posedge i_sys_clk);
    o_sel_n <= 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      drv_en  <= !(w[23] && i < 16);
      drv_bit <= w[i];
      repeat (6) @(posedge i_sys_clk);
      if (i < 16) rv[i] = four ? sdo_wire : o_sdio;
      o_sclk <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      o_sclk <= 1'b0;
    end
    repeat (6) @(posedge i_sys_clk);
    drv_en  <= 1'b0;
    o_sel_n <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
  endtask
endmodule

// ---- bench/ccp_pins_chk.sv ----
`timescale 1ns/1ps
// ============================================================================
// port checker for the control pin block
// ============================================================================
module ccp_pins_chk #(
  parameter int DW = 16
) (
  input wire logic          i_sys_clk,
  input wire logic          i_arst_n,
  input wire logic          i_register_reset_n,
  input wire logic          i_serial_select_n,
  input wire logic          o_serial_data_oe,
  input wire logic          o_serial_read_out_oe,
  input wire logic          i_transmit_gate,
  input wire logic          i_sleep,
  input wire logic          o_alarm,
  input wire logic [DW-1:0] i_sample,
  input wire logic          i_sample_valid,
  input wire logic [DW-1:0] o_dac_code,
  input wire logic [DW-1:0] o_pos_current_out,
  input wire logic [DW-1:0] o_neg_current_out,
  input wire logic [1:0]    o_lane_enable,
  input wire logic          o_sleeping,
  input wire logic          o_irq
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ==========================================================================
  // serial pin drivers
  // ==========================================================================
  AST_ONE_PIN: assert property (!(o_serial_data_oe && o_serial_read_out_oe))
    else $error("both serial pins driven");
  AST_OE_FRAME: assert property ($rose(o_serial_data_oe || o_serial_read_out_oe) |-> !i_serial_select_n)
    else $error("serial pin driven outside a frame");
  // sync delay of select is two flops, then engine and output flops; five cycles is just enough
  AST_OE_DROP: assert property (i_serial_select_n[*5] |-> !o_serial_data_oe && !o_serial_read_out_oe)
    else $error("serial pin still driven after frame");

  // ==========================================================================
  // reset, datapath, sleep and alarm
  // ==========================================================================
  AST_REG_RESET: assert property (!i_register_reset_n |-> o_lane_enable == 2'b11 && o_dac_code == '0 && !o_alarm)
    else $error("register reset did not restore defaults");
  AST_OFFSET: assert property (o_pos_current_out == ~o_neg_current_out)
    else $error("positive current not complement of code");
  AST_GATE_ZERO: assert property (!i_transmit_gate[*5] |-> o_dac_code == '0)
    else $error("datapath not zero while gate low");
  AST_CODE_SRC: assert property ($changed(o_dac_code) && o_dac_code != '0
    |-> $past(i_sample_valid) && o_dac_code == $past(i_sample))
    else $error("code changed without a sample");
  AST_SLEEP_ON: assert property ((i_sleep && i_register_reset_n)[*6] |-> o_sleeping)
    else $error("sleep input not obeyed");
  AST_SLEEP_OFF: assert property (!i_sleep[*4] |-> !o_sleeping)
    else $error("sleeping with sleep input low");
  AST_ALARM: assert property ((i_register_reset_n && !i_transmit_gate)[*6] ##0 i_sample_valid
    |-> ##[1:3] o_alarm)
    else $error("gated sample raised no alarm");
  AST_IRQ: assert property (o_irq |-> o_alarm)
    else $error("interrupt without alarm");

  // main scenarios
  cover property (o_serial_data_oe);
  cover property (o_serial_read_out_oe);
  cover property (o_irq);
endmodule

bind ccp_control_pins ccp_pins_chk #(.DW(DW)) i_chk (.i_sys_clk, .i_arst_n, .i_register_reset_n,
  .i_serial_select_n, .o_serial_data_oe, .o_serial_read_out_oe, .i_transmit_gate, .i_sleep, .o_alarm,
  .i_sample, .i_sample_valid, .o_dac_code, .o_pos_current_out, .o_neg_current_out, .o_lane_enable,
  .o_sleeping, .o_irq);

// ---- bench/tb_converter_control_pin_logic.sv ----
`timescale 1ns/1ps
module tb_converter_control_pin_logic;
  logic        clk, arst_n, rrst_n, sclk, sel_n, sdin, dout, doe, rout, roe;
  logic        gate, sleep, alarm, svalid, sleeping, wr, rd, irq;
  logic [15:0] sample, code, pos, rv;
  logic [1:0]  lanes;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  int          error_cnt, tests_run;
  logic [15:0] codes[3] = '{16'h1234, 16'h0000, 16'hFFFF};

  ccp_control_pins #(.DW(16)) i_dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_register_reset_n(rrst_n),
    .i_serial_clk(sclk), .i_serial_select_n(sel_n), .i_serial_data_in(sdin), .o_serial_data_out(dout),
    .o_serial_data_oe(doe), .o_serial_read_out(rout), .o_serial_read_out_oe(roe), .i_transmit_gate(gate),
    .i_sleep(sleep), .o_alarm(alarm), .i_sample(sample), .i_sample_valid(svalid), .o_dac_code(code),
    .o_pos_current_out(pos), .o_neg_current_out(), .o_lane_enable(lanes), .o_sleeping(sleeping),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
  ccp_host_model i_host (.i_sys_clk(clk), .i_dev_sdio(dout), .i_dev_sdio_oe(doe), .i_dev_sdo(rout),
    .i_dev_sdo_oe(roe), .o_sclk(sclk), .o_sel_n(sel_n), .o_sdio(sdin));

  // ==========================================================================
  // clock, helpers
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic put(input logic [15:0] d);
    @(posedge clk);
    sample <= d;
    svalid <= 1'b1;
    @(posedge clk);
    svalid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a full run is some 2100 clocks
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    {arst_n, rrst_n, gate, sleep, svalid, wr, rd} = '0;
    sample = '0;
    addr   = '0;
    wdata  = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({30'h0, lanes}, 32'h0000_0003);
    check({16'h0, pos}, 32'h0000_FFFF);
    bus_rd(ccp_pkg::BUS_CONFIG_OFS, {16'h0, ccp_pkg::CFG_RESET});
    bus_rd(8'h10, 32'h0000_0000);
    // three-pin: serial write lanes, read back on the data pin
    i_host.frame(24'h00_0001, 24, 1'b0, rv);
    check({30'h0, lanes}, 32'h0000_0001);
    i_host.frame(24'h80_0000, 24, 1'b0, rv);
    check({16'h0, rv}, 32'h0000_0001);
    // four-wire: answer must come on the dedicated pin
    bus_wr(ccp_pkg::BUS_CONFIG_OFS, 32'h0000_0203);
    bus_rd(ccp_pkg::BUS_STATE_OFS, 32'h0000_0004);
    i_host.frame(24'h80_0000, 24, 1'b1, rv);
    check({16'h0, rv}, 32'h0000_0203);
    i_host.frame(24'h00_0000, 12, 1'b1, rv);
    bus_rd(ccp_pkg::BUS_CONFIG_OFS, 32'h0000_0203);
    i_host.frame(24'h00_0003, 24, 1'b1, rv);
    bus_rd(ccp_pkg::BUS_CONFIG_OFS, 32'h0000_0003);
    // unmapped serial write raises a sticky event
    bus_wr(ccp_pkg::BUS_MASK_OFS, 32'h0000_0007);
    i_host.frame(24'h05_1234, 24, 1'b0, rv);
    i_host.frame(24'h81_0000, 24, 1'b0, rv);
    check({16'h0, rv}, 32'h0000_0004);
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0004);
    check({30'h0, alarm, irq}, 32'h0000_0003);
    bus_wr(ccp_pkg::BUS_MASK_OFS, 32'h0000_0000);
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0004);
    check({30'h0, alarm, irq}, 32'h0000_0002);
    bus_wr(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0004);
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0000);
    check({31'h0, alarm}, 32'h0000_0000);
    // gate open: codes pass, boundary codes of the current output
    @(posedge clk);
    gate <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (codes[i]) begin
      put(codes[i]);
      check({16'h0, code}, {16'h0, codes[i]});
      check({16'h0, pos}, {16'h0, ~codes[i]});
    end
    // gate shut: zero and samples ignored
    @(posedge clk);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    put(16'h5555);
    check({16'h0, code}, 32'h0000_0000);
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0001);
    bus_wr(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0001);
    // sleep with the gate open
    gate  <= 1'b1;
    sleep <= 1'b1;
    repeat (6) @(posedge clk);
    put(16'h00AA);
    check({31'h0, sleeping}, 32'h0000_0001);
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0002);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({31'h0, sleeping}, 32'h0000_0000);
    // register reset pin in mid-run
    bus_wr(ccp_pkg::BUS_CONFIG_OFS, 32'h0000_0200);
    rrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus_rd(ccp_pkg::BUS_CONFIG_OFS, {16'h0, ccp_pkg::CFG_RESET});
    bus_rd(ccp_pkg::BUS_STATUS_OFS, 32'h0000_0000);
    results();
  end
endmodule

// ---- rtl/ccp_control_pins.sv ----
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - three-pin mode: bidirectional data pin takes writes and returns read data.
// - four-wire select bit nine set makes the bidirectional pin input only.
// - serial read output drives only in four-wire mode, else released.
// - register reset pin low clears configuration registers at once, clocklessly.
// - transmit gate low forces datapath to zero and ignores samples.
// - sleep input high sleeps the device; low keeps it running.
// - alarm conditions show on a dedicated alarm output.
// - offset binary: zero code gives full positive current, all ones gives none.
module ccp_control_pins #(
  parameter int DW = 16
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_arst_n,
  // pins from the host
  input  wire logic          i_register_reset_n,
  input  wire logic          i_serial_clk,
  input  wire logic          i_serial_select_n,
  input  wire logic          i_serial_data_in,
  output logic               o_serial_data_out,
  output logic               o_serial_data_oe,
  output logic               o_serial_read_out,
  output logic               o_serial_read_out_oe,
  input  wire logic          i_transmit_gate,
  input  wire logic          i_sleep,
  output logic               o_alarm,
  // sample path, same clock
  input  wire logic [DW-1:0] i_sample,
  input  wire logic          i_sample_valid,
  output logic [DW-1:0]      o_dac_code,
  output logic [DW-1:0]      o_pos_current_out,
  output logic [DW-1:0]      o_neg_current_out,
  output logic [1:0]         o_lane_enable,
  output logic               o_sleeping,
  // register port
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [31:0]   i_reg_wdata,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  output logic [31:0]        o_reg_rdata,
  output logic               o_irq
);

  // ==========================================================================
  // reset: either reset pin clears at once, release is synchronised
  // ==========================================================================
  logic cfg_arst_n;
  logic cfg_rst_n;

  // either pin clears the flops with no clock edge
  assign cfg_arst_n = i_arst_n & i_register_reset_n;

  // release waits two edges; no flop sees a runt
  ccp_sync2 #(
    .RST_VAL (1'b0)
  ) u_rst_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (cfg_arst_n),
    .i_d       (1'b1),
    .o_q       (cfg_rst_n)
  );

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic sclk_s;
  logic sel_n_s;
  logic sdin_s;
  logic gate_s;
  logic sleep_s;

  // two flops per pin before any logic reads it
  ccp_sync2 #(.RST_VAL (1'b0)) u_sync_sclk (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_serial_clk),
    .o_q       (sclk_s)
  );

  ccp_sync2 #(.RST_VAL (1'b1)) u_sync_sel (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_serial_select_n),
    .o_q       (sel_n_s)
  );

  ccp_sync2 #(.RST_VAL (1'b0)) u_sync_sdin (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_serial_data_in),
    .o_q       (sdin_s)
  );

  ccp_sync2 #(.RST_VAL (1'b0)) u_sync_gate (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_transmit_gate),
    .o_q       (gate_s)
  );

  ccp_sync2 #(.RST_VAL (1'b0)) u_sync_sleep (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_sleep),
    .o_q       (sleep_s)
  );

  // ==========================================================================
  // serial port
  // ==========================================================================
  logic [6:0]  ser_addr;
  logic [15:0] ser_wdata;
  logic        ser_wr;
  logic        ser_rd_phase;
  logic        ser_bit;
  logic        ser_busy;
  logic [15:0] ser_rdata;

  // a register reset also aborts a frame in flight
  ccp_serial_engine u_serial (
    .i_sys_clk    (i_sys_clk),
    .i_arst_n     (cfg_rst_n),
    .i_sclk_s     (sclk_s),
    .i_select_n_s (sel_n_s),
    .i_sdin_s     (sdin_s),
    .i_rd_data    (ser_rdata),
    .o_addr       (ser_addr),
    .o_wr_data    (ser_wdata),
    .o_wr_pulse   (ser_wr),
    .o_rd_phase   (ser_rd_phase),
    .o_out_bit    (ser_bit),
    .o_busy       (ser_busy)
  );

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [15:0]                 cfg_r, cfg_nxt;
  logic [ccp_pkg::EVT_BITS-1:0] status_r, status_nxt;
  logic [ccp_pkg::EVT_BITS-1:0] mask_r, mask_nxt;
  logic [ccp_pkg::EVT_BITS-1:0] evt;
  logic                        four_wire;
  logic                        bus_hit_cfg;
  logic                        bus_hit_sts;
  logic                        bus_hit_msk;
  logic                        ser_bad;

  // write decode and the engine's bad address
  assign four_wire   = cfg_r[ccp_pkg::CFG_FOUR_WIRE];
  assign bus_hit_cfg = i_reg_wr & (i_reg_addr == ccp_pkg::BUS_CONFIG_OFS);
  assign bus_hit_sts = i_reg_wr & (i_reg_addr == ccp_pkg::BUS_STATUS_OFS);
  assign bus_hit_msk = i_reg_wr & (i_reg_addr == ccp_pkg::BUS_MASK_OFS);
  assign ser_bad     = ser_wr & (ser_addr != ccp_pkg::SER_CONFIG0_ADR);

  // event sources: samples lost to the gate or to sleep, bad serial writes
  always_comb begin
    evt                       = '0;
    evt[ccp_pkg::EVT_GATED]    = i_sample_valid & ~gate_s;
    evt[ccp_pkg::EVT_ASLEEP]   = i_sample_valid & sleep_s;
    evt[ccp_pkg::EVT_BAD_ADDR] = ser_bad;
  end

  // serial write wins over a bus write in the same cycle; event set beats clear
  always_comb begin
    cfg_nxt    = cfg_r;
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (bus_hit_cfg) begin
      cfg_nxt = i_reg_wdata[15:0] & ccp_pkg::CFG_WR_MASK;
    end
    if (ser_wr && (ser_addr == ccp_pkg::SER_CONFIG0_ADR)) begin
      cfg_nxt = ser_wdata & ccp_pkg::CFG_WR_MASK;
    end
    if (bus_hit_sts) begin
      status_nxt = status_r & ~i_reg_wdata[ccp_pkg::EVT_BITS-1:0];
    end
    status_nxt = status_nxt | evt;
    if (bus_hit_msk) begin
      mask_nxt = i_reg_wdata[ccp_pkg::EVT_BITS-1:0];
    end
  end

  // cleared by either reset; no clock edge needed to enter defaults
  always_ff @(posedge i_sys_clk or negedge cfg_rst_n) begin
    if (!cfg_rst_n) begin
      cfg_r    <= ccp_pkg::CFG_RESET;
      status_r <= ccp_pkg::EVT_RESET;
      mask_r   <= ccp_pkg::EVT_RESET;
    end else begin
      cfg_r    <= cfg_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // serial readback view: config word or event flags
  always_comb begin
    ser_rdata = 16'h0000;
    case (ser_addr)
      ccp_pkg::SER_CONFIG0_ADR: ser_rdata = cfg_r;
      ccp_pkg::SER_STATUS_ADR:  ser_rdata[ccp_pkg::EVT_BITS-1:0] = status_r;
      default:                  ser_rdata = 16'h0000;
    endcase
  end

  // ==========================================================================
  // bus read data, valid only in the cycle after the strobe
  // ==========================================================================
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ccp_pkg::BUS_CONFIG_OFS: rdata_nxt[15:0] = cfg_r;
        ccp_pkg::BUS_STATUS_OFS: rdata_nxt[ccp_pkg::EVT_BITS-1:0] = status_r;
        ccp_pkg::BUS_MASK_OFS:   rdata_nxt[ccp_pkg::EVT_BITS-1:0] = mask_r;
        ccp_pkg::BUS_STATE_OFS: begin
          rdata_nxt[ccp_pkg::ST_SLEEP]     = sleep_s;
          rdata_nxt[ccp_pkg::ST_GATE]      = gate_s;
          rdata_nxt[ccp_pkg::ST_FOUR_WIRE] = four_wire;
          rdata_nxt[ccp_pkg::ST_SER_BUSY]  = ser_busy;
        end
        default: rdata_nxt = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // ==========================================================================
  // datapath and current steering
  // ==========================================================================
  // all-zero code means full current on the positive output
  function automatic logic [DW-1:0] pos_level(input logic [DW-1:0] code);
    pos_level = ~code;
  endfunction

  // last accepted code, held between samples
  logic [DW-1:0] code_r, code_nxt;

  // gate low or sleep zeroes the path; samples are held off, not queued
  always_comb begin
    code_nxt = code_r;
    if (!gate_s || sleep_s) begin
      code_nxt = '0;
    end else if (i_sample_valid) begin
      code_nxt = i_sample;
    end
  end

  // ==========================================================================
  // pin drivers: one select bit steers both output enables
  // ==========================================================================
  logic sdio_oe_nxt;
  logic sdo_oe_nxt;
  logic alarm_nxt;
  logic irq_nxt;

  always_comb begin
    sdio_oe_nxt = ser_rd_phase & ~four_wire;
    sdo_oe_nxt  = ser_rd_phase & four_wire;
    alarm_nxt   = |status_r;
    irq_nxt     = |(status_r & mask_r);
  end

  // every output registered; read data settle one cycle behind the engine
  always_ff @(posedge i_sys_clk or negedge cfg_rst_n) begin
    if (!cfg_rst_n) begin
      code_r               <= '0;
      o_dac_code           <= '0;
      o_pos_current_out    <= '1;
      o_neg_current_out    <= '0;
      o_serial_data_out    <= 1'b0;
      o_serial_data_oe     <= 1'b0;
      o_serial_read_out    <= 1'b0;
      o_serial_read_out_oe <= 1'b0;
      o_alarm              <= 1'b0;
      o_irq                <= 1'b0;
      o_reg_rdata          <= 32'h0000_0000;
      o_lane_enable        <= ccp_pkg::CFG_RESET[1:0];
      o_sleeping           <= 1'b0;
    end else begin
      code_r               <= code_nxt;
      o_dac_code           <= code_nxt;
      o_pos_current_out    <= pos_level(code_nxt);
      o_neg_current_out    <= code_nxt;
      o_serial_data_out    <= ser_bit & ~four_wire;
      o_serial_data_oe     <= sdio_oe_nxt;
      o_serial_read_out    <= ser_bit & four_wire;
      o_serial_read_out_oe <= sdo_oe_nxt;
      o_alarm              <= alarm_nxt;
      o_irq                <= irq_nxt;
      o_reg_rdata          <= rdata_nxt;
      o_lane_enable        <= cfg_r[ccp_pkg::CFG_LANE_LSB +: ccp_pkg::CFG_LANE_BITS];
      o_sleeping           <= sleep_s;
    end
  end

endmodule

// ---- rtl/ccp_pkg.sv ----
package ccp_pkg;

  // ==========================================================================
  // host register bus map (byte addresses, one word each)
  // ==========================================================================
  localparam logic [7:0]  BUS_CONFIG_OFS   = 8'h00;
  localparam logic [7:0]  BUS_STATUS_OFS   = 8'h04;
  localparam logic [7:0]  BUS_MASK_OFS     = 8'h08;
  localparam logic [7:0]  BUS_STATE_OFS    = 8'h0C;

  // ==========================================================================
  // configuration register 0 layout
  // ==========================================================================
  localparam int          CFG_WIDTH        = 16;
  localparam int          CFG_FOUR_WIRE    = 9;
  localparam int          CFG_LANE_LSB     = 0;
  localparam int          CFG_LANE_BITS    = 2;
  localparam logic [15:0] CFG_RESET        = 16'h0003;
  localparam logic [15:0] CFG_WR_MASK      = 16'h0203;

  // ==========================================================================
  // sticky event bits (status and mask share this layout)
  // ==========================================================================
  localparam int          EVT_BITS         = 3;
  localparam int          EVT_GATED        = 0;
  localparam int          EVT_ASLEEP       = 1;
  localparam int          EVT_BAD_ADDR     = 2;
  localparam logic [2:0]  EVT_RESET        = 3'h0;

  // ==========================================================================
  // state register layout (read only)
  // ==========================================================================
  localparam int          ST_SLEEP         = 0;
  localparam int          ST_GATE          = 1;
  localparam int          ST_FOUR_WIRE     = 2;
  localparam int          ST_SER_BUSY      = 3;

  // ==========================================================================
  // serial frame: r/w bit, 7-bit address, 16 data bits, msb first
  // ==========================================================================
  localparam int          SER_ADDR_BITS    = 7;
  localparam logic [4:0]  SER_HDR_BITS     = 5'h08;
  localparam logic [4:0]  SER_FRAME_BITS   = 5'h18;
  localparam logic [6:0]  SER_CONFIG0_ADR  = 7'h00;
  localparam logic [6:0]  SER_STATUS_ADR   = 7'h01;

  // serial port engine states
  typedef enum logic [2:0] {
    CCP_SER_IDLE = 3'b001,
    CCP_SER_HDR  = 3'b010,
    CCP_SER_DATA = 3'b100
  } ccp_ser_state_e;

endpackage

// ---- rtl/ccp_serial_engine.sv ----
`timescale 1ns/1ps
// ============================================================================
// serial frame engine on oversampled, already synchronised pins
// ============================================================================
module ccp_serial_engine (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_sclk_s,
  input  wire logic        i_select_n_s,
  input  wire logic        i_sdin_s,
  input  wire logic [15:0] i_rd_data,
  output logic [6:0]       o_addr,
  output logic [15:0]      o_wr_data,
  output logic             o_wr_pulse,
  output logic             o_rd_phase,
  output logic             o_out_bit,
  output logic             o_busy
);

  ccp_pkg::ccp_ser_state_e state_r, state_nxt;
  logic        sclk_d_r;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [23:0] shin_r, shin_nxt;
  logic [15:0] shout_r, shout_nxt;
  logic        rd_r, rd_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic        wr_nxt;
  logic        rise;

  assign rise = i_sclk_s & ~sclk_d_r;

  // ==========================================================================
  // frame sequencing; select high aborts any frame in flight
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shin_nxt  = shin_r;
    shout_nxt = shout_r;
    rd_nxt    = rd_r;
    addr_nxt  = addr_r;
    wr_nxt    = 1'b0;
    case (state_r)
      ccp_pkg::CCP_SER_IDLE: begin
        cnt_nxt = 5'h00;
        rd_nxt  = 1'b0;
        if (!i_select_n_s) begin
          state_nxt = ccp_pkg::CCP_SER_HDR;
        end
      end
      ccp_pkg::CCP_SER_HDR: begin
        if (i_select_n_s) begin
          state_nxt = ccp_pkg::CCP_SER_IDLE;
        end else if (rise) begin
          shin_nxt = {shin_r[22:0], i_sdin_s};
          cnt_nxt  = cnt_r + 5'h01;
          if (cnt_r + 5'h01 == ccp_pkg::SER_HDR_BITS) begin
            state_nxt = ccp_pkg::CCP_SER_DATA;
            rd_nxt    = shin_r[6];          // r/w bit is the first one in
            addr_nxt  = {shin_r[5:0], i_sdin_s};
            shout_nxt = i_rd_data;          // read data latched at header end
          end
        end
      end
      ccp_pkg::CCP_SER_DATA: begin
        if (i_select_n_s) begin
          state_nxt = ccp_pkg::CCP_SER_IDLE;
        end else if (rise) begin
          shin_nxt  = {shin_r[22:0], i_sdin_s};
          shout_nxt = {shout_r[14:0], 1'b0};
          cnt_nxt   = cnt_r + 5'h01;
          if (cnt_r + 5'h01 == ccp_pkg::SER_FRAME_BITS) begin
            state_nxt = ccp_pkg::CCP_SER_IDLE;
            wr_nxt    = ~rd_r;
          end
        end
      end
      default: begin
        state_nxt = ccp_pkg::CCP_SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r    <= ccp_pkg::CCP_SER_IDLE;
      sclk_d_r   <= 1'b0;
      cnt_r      <= 5'h00;
      shin_r     <= 24'h00_0000;
      shout_r    <= 16'h0000;
      rd_r       <= 1'b0;
      addr_r     <= 7'h00;
      o_wr_pulse <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      sclk_d_r   <= i_sclk_s;
      cnt_r      <= cnt_nxt;
      shin_r     <= shin_nxt;
      shout_r    <= shout_nxt;
      rd_r       <= rd_nxt;
      addr_r     <= addr_nxt;
      o_wr_pulse <= wr_nxt;
    end
  end

  // live address at header end for read data, then held for the write pulse
  assign o_addr     = (state_r == ccp_pkg::CCP_SER_HDR) ? {shin_r[5:0], i_sdin_s} : addr_r;
  assign o_wr_data  = shin_r[15:0];
  assign o_rd_phase = rd_r & (state_r == ccp_pkg::CCP_SER_DATA);
  assign o_out_bit  = shout_r[15];
  assign o_busy     = (state_r != ccp_pkg::CCP_SER_IDLE);

endmodule

// ---- rtl/ccp_sync2.sv ----
`timescale 1ns/1ps
// ============================================================================
// two flip-flop level synchroniser
// ============================================================================
module ccp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = i_d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      o_q    <= q_nxt;
    end
  end

endmodule
